/* rtl/tcm_access_timer.sv */
// access length counter: runs one access for a given number of cycles
// assumes cycles_i is between 1 and 8 when start_i is high

`timescale 1ns/10ps

module tcm_access_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic start_i,
    input wire logic [3:0] cycles_i,
    // status
    output logic last_o
);

    logic busy_r;
    logic [3:0] cnt_r;

    // ==========================================================
    // count down the remaining cycles of the access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
        end else if (start_i) begin
            busy_r <= 1'b1;
            cnt_r <= cycles_i - 4'h1;
        end else if (busy_r && cnt_r == 4'h0) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end

    assign last_o = busy_r && (cnt_r == 4'h0);

endmodule // tcm_access_timer

/* rtl/tcm_mem_if.sv */
// processor to block ram interface: data side and instruction side ports
// assumes ram read data is valid during any cycle its enable is high
//
// Overview of operation
// - each side runs single-cycle or multi-cycle (two to eight cycles)
// - each side decodes its own 16 MB region of the address map
// - direct address bits reach 16M bytes data, 16M bytes instruction
// - data side has separate 32-bit read and write buses
// - data writes carry byte enables; other lanes stay unchanged
// - data side drives a 22-bit ram address
// - data side has 8-bit control and address range registers
// - instruction side reads 64 bits, two instructions per access
// - instruction side has a 32-bit write-only path via control bus
// - instruction side drives its own 21-bit ram address
// - instruction side has 8-bit control and address range registers
// - instruction side has 32-bit init data and fill registers
// - control bus base addresses of both sides are parameters
// - control bus has a 10-bit address space of its own

`timescale 1ns/10ps

module tcm_mem_if #(
    parameter logic [9:0] DS_CBUS_BASE = 10'h010,
    parameter logic [9:0] IS_CBUS_BASE = 10'h018
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    // control register bus
    input wire logic [9:0] CBUS_ADDR_I,
    input wire logic CBUS_RD_I,
    input wire logic CBUS_WR_I,
    input wire logic [31:0] CBUS_WDATA_I,
    output logic [31:0] CBUS_RDATA_O,
    output logic CBUS_ACK_O,
    // processor data side
    input wire logic DS_REQ_I,
    input wire logic DS_WE_I,
    input wire logic [3:0] DS_BE_I,
    input wire logic [31:0] DS_ADDR_I,
    input wire logic [31:0] DS_WDATA_I,
    output logic [31:0] DS_RDATA_O,
    output logic DS_DONE_O,
    // data side ram
    output logic DMEM_EN_O,
    output logic [3:0] DMEM_WE_O,
    output logic [21:0] DMEM_ADDR_O,
    output logic [31:0] DMEM_WDATA_O,
    input wire logic [31:0] DMEM_RDATA_I,
    // processor instruction side
    input wire logic IS_REQ_I,
    input wire logic [31:0] IS_ADDR_I,
    output logic [63:0] IS_RDATA_O,
    output logic IS_DONE_O,
    // instruction side ram
    output logic IMEM_EN_O,
    output logic [1:0] IMEM_WE_O,
    output logic [20:0] IMEM_ADDR_O,
    output logic [31:0] IMEM_WDATA_O,
    input wire logic [63:0] IMEM_RDATA_I
);

    // ==========================================================
    // elaboration checks
    generate
        if (int'(DS_CBUS_BASE) + tcm_pkg::DS_REG_COUNT > 1024 ||
            int'(IS_CBUS_BASE) + tcm_pkg::IS_REG_COUNT > 1024) begin : g_rng
            $error("base past control bus space");
        end
        if (int'(DS_CBUS_BASE) < int'(IS_CBUS_BASE) + tcm_pkg::IS_REG_COUNT &&
            int'(IS_CBUS_BASE) < int'(DS_CBUS_BASE) + tcm_pkg::DS_REG_COUNT)
        begin : g_ovl
            $error("register blocks overlap");
        end
    endgenerate

    // ==========================================================
    // decode functions
    function automatic logic [3:0] access_cycles(input logic [7:0] ctl);
        logic [3:0] n;
        n = {1'b0, ctl[tcm_pkg::CTL_CNT_LSB +: tcm_pkg::CTL_CNT_W]} + 4'h1;
        if (!ctl[tcm_pkg::CTL_MULTI_BIT]) begin
            access_cycles = tcm_pkg::SINGLE_CYCLES;
        end else if (n < tcm_pkg::MULTI_MIN_CYCLES) begin
            access_cycles = tcm_pkg::MULTI_MIN_CYCLES;
        end else begin
            access_cycles = n;
        end
    endfunction

    function automatic logic region_hit(input logic [31:0] addr,
                                        input logic [7:0] range);
        region_hit = (addr[31:tcm_pkg::REGION_LSB] == range);
    endfunction

    // ==========================================================
    // registers and state
    logic [7:0] ds_ctrl_r;
    logic [7:0] ds_range_r;
    logic [7:0] is_ctrl_r;
    logic [7:0] is_range_r;
    logic [31:0] is_init_r;
    logic [31:0] is_fill_r;
    logic wr_pend_r;
    tcm_pkg::tcm_ds_state_t ds_state_r;
    tcm_pkg::tcm_is_state_t is_state_r;

    logic [9:0] ds_ofs;
    logic [9:0] is_ofs;
    logic ds_sel;
    logic is_sel;
    logic cb_wr;
    logic ds_start;
    logic is_fetch_start;
    logic is_write_start;
    logic ds_last;
    logic is_last;
    logic init_wr;

    // base addresses come from parameters, offsets from the package
    assign ds_ofs = CBUS_ADDR_I - DS_CBUS_BASE;
    assign is_ofs = CBUS_ADDR_I - IS_CBUS_BASE;
    assign ds_sel = (CBUS_ADDR_I >= DS_CBUS_BASE) &&
                    (ds_ofs < 10'(tcm_pkg::DS_REG_COUNT));
    assign is_sel = (CBUS_ADDR_I >= IS_CBUS_BASE) &&
                    (is_ofs < 10'(tcm_pkg::IS_REG_COUNT));
    assign cb_wr = CBUS_WR_I && !CBUS_RD_I;
    assign init_wr = cb_wr && is_sel && is_ofs == tcm_pkg::IS_INIT_OFS;

    assign ds_start = (ds_state_r == tcm_pkg::TCM_DS_IDLE) && DS_REQ_I &&
                      ds_ctrl_r[tcm_pkg::CTL_EN_BIT] &&
                      region_hit(DS_ADDR_I, ds_range_r);
    assign is_write_start = (is_state_r == tcm_pkg::TCM_IS_IDLE) && wr_pend_r;
    assign is_fetch_start = (is_state_r == tcm_pkg::TCM_IS_IDLE) &&
                            !wr_pend_r && IS_REQ_I &&
                            is_ctrl_r[tcm_pkg::CTL_EN_BIT] &&
                            region_hit(IS_ADDR_I, is_range_r);

    // ==========================================================
    // access timers
    tcm_access_timer u_ds_timer (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .start_i(ds_start),
        .cycles_i(access_cycles(ds_ctrl_r)),
        .last_o(ds_last)
    );

    tcm_access_timer u_is_timer (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .start_i(is_fetch_start || is_write_start),
        .cycles_i(access_cycles(is_ctrl_r)),
        .last_o(is_last)
    );

    // ==========================================================
    // control bus register writes
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ds_ctrl_r <= tcm_pkg::CTL_RST;
            ds_range_r <= tcm_pkg::RANGE_RST;
            is_ctrl_r <= tcm_pkg::CTL_RST;
            is_range_r <= tcm_pkg::RANGE_RST;
            is_init_r <= tcm_pkg::INIT_RST;
        end else if (cb_wr) begin
            if (ds_sel && ds_ofs == tcm_pkg::DS_CTRL_OFS) begin
                ds_ctrl_r <= CBUS_WDATA_I[7:0];
            end
            if (ds_sel && ds_ofs == tcm_pkg::DS_RANGE_OFS) begin
                ds_range_r <= CBUS_WDATA_I[7:0];
            end
            if (is_sel && is_ofs == tcm_pkg::IS_CTRL_OFS) begin
                is_ctrl_r <= CBUS_WDATA_I[7:0];
            end
            if (is_sel && is_ofs == tcm_pkg::IS_RANGE_OFS) begin
                is_range_r <= CBUS_WDATA_I[7:0];
            end
            if (init_wr) begin
                is_init_r <= CBUS_WDATA_I;
            end
        end
    end

    // fill address: software write wins over the post-write step
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            is_fill_r <= tcm_pkg::FILL_RST;
        end else if (cb_wr && is_sel && is_ofs == tcm_pkg::IS_FILL_OFS) begin
            is_fill_r <= CBUS_WDATA_I;
        end else if (is_state_r == tcm_pkg::TCM_IS_WRITE && is_last) begin
            is_fill_r <= is_fill_r + tcm_pkg::FILL_STEP;
        end
    end

    // pending init write: a new request wins over the clear
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_pend_r <= 1'b0;
        end else if (init_wr) begin
            wr_pend_r <= 1'b1;
        end else if (is_write_start) begin
            wr_pend_r <= 1'b0;
        end
    end

    // ==========================================================
    // control bus reads and acknowledge
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CBUS_ACK_O <= 1'b0;
            CBUS_RDATA_O <= 32'h0;
        end else begin
            CBUS_ACK_O <= (CBUS_RD_I || CBUS_WR_I) && (ds_sel || is_sel);
            CBUS_RDATA_O <= 32'h0;
            if (CBUS_RD_I && ds_sel) begin
                case (ds_ofs)
                    tcm_pkg::DS_CTRL_OFS: CBUS_RDATA_O <= {24'h0, ds_ctrl_r};
                    tcm_pkg::DS_RANGE_OFS: CBUS_RDATA_O <= {24'h0, ds_range_r};
                    default: CBUS_RDATA_O <= 32'h0;
                endcase
            end else if (CBUS_RD_I && is_sel) begin
                case (is_ofs)
                    tcm_pkg::IS_CTRL_OFS: CBUS_RDATA_O <= {24'h0, is_ctrl_r};
                    tcm_pkg::IS_RANGE_OFS: CBUS_RDATA_O <= {24'h0, is_range_r};
                    tcm_pkg::IS_INIT_OFS: CBUS_RDATA_O <= is_init_r;
                    tcm_pkg::IS_FILL_OFS: CBUS_RDATA_O <= is_fill_r;
                    default: CBUS_RDATA_O <= 32'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // data side sequencer
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ds_state_r <= tcm_pkg::TCM_DS_IDLE;
            DMEM_EN_O <= 1'b0;
            DMEM_WE_O <= 4'h0;
            DMEM_ADDR_O <= 22'h0;
            DMEM_WDATA_O <= 32'h0;
        end else begin
            case (ds_state_r)
                tcm_pkg::TCM_DS_IDLE: begin
                    if (ds_start) begin
                        ds_state_r <= tcm_pkg::TCM_DS_BUSY;
                        DMEM_EN_O <= 1'b1;
                        DMEM_WE_O <= DS_BE_I & {4{DS_WE_I}};
                        DMEM_ADDR_O <= DS_ADDR_I[23:2];
                        DMEM_WDATA_O <= DS_WDATA_I;
                    end
                end
                tcm_pkg::TCM_DS_BUSY: begin
                    if (ds_last) begin
                        ds_state_r <= tcm_pkg::TCM_DS_IDLE;
                        DMEM_EN_O <= 1'b0;
                        DMEM_WE_O <= 4'h0;
                    end
                end
                default: begin
                    ds_state_r <= tcm_pkg::TCM_DS_IDLE;
                end
            endcase
        end
    end

    // data side answer: read data taken in the final cycle only
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DS_RDATA_O <= 32'h0;
            DS_DONE_O <= 1'b0;
        end else begin
            DS_DONE_O <= (ds_state_r == tcm_pkg::TCM_DS_BUSY) && ds_last;
            if (ds_state_r == tcm_pkg::TCM_DS_BUSY && ds_last &&
                DMEM_WE_O == 4'h0) begin
                DS_RDATA_O <= DMEM_RDATA_I;
            end
        end
    end

    // ==========================================================
    // instruction side sequencer
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            is_state_r <= tcm_pkg::TCM_IS_IDLE;
            IMEM_EN_O <= 1'b0;
            IMEM_WE_O <= 2'h0;
            IMEM_ADDR_O <= 21'h0;
            IMEM_WDATA_O <= 32'h0;
        end else begin
            case (is_state_r)
                tcm_pkg::TCM_IS_IDLE: begin
                    if (is_write_start) begin
                        is_state_r <= tcm_pkg::TCM_IS_WRITE;
                        IMEM_EN_O <= 1'b1;
                        IMEM_WE_O <= is_fill_r[2] ? 2'h2 : 2'h1;
                        IMEM_ADDR_O <= is_fill_r[23:3];
                        IMEM_WDATA_O <= is_init_r;
                    end else if (is_fetch_start) begin
                        is_state_r <= tcm_pkg::TCM_IS_FETCH;
                        IMEM_EN_O <= 1'b1;
                        IMEM_WE_O <= 2'h0;
                        IMEM_ADDR_O <= IS_ADDR_I[23:3];
                    end
                end
                tcm_pkg::TCM_IS_FETCH,
                tcm_pkg::TCM_IS_WRITE: begin
                    if (is_last) begin
                        is_state_r <= tcm_pkg::TCM_IS_IDLE;
                        IMEM_EN_O <= 1'b0;
                        IMEM_WE_O <= 2'h0;
                    end
                end
                default: begin
                    is_state_r <= tcm_pkg::TCM_IS_IDLE;
                end
            endcase
        end
    end

    // instruction side answer: two instructions per fetch
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IS_RDATA_O <= 64'h0;
            IS_DONE_O <= 1'b0;
        end else begin
            IS_DONE_O <= (is_state_r == tcm_pkg::TCM_IS_FETCH) && is_last;
            if (is_state_r == tcm_pkg::TCM_IS_FETCH && is_last) begin
                IS_RDATA_O <= IMEM_RDATA_I;
            end
        end
    end

endmodule // tcm_mem_if

/* rtl/tcm_pkg.sv */
// constants, field layouts and state types for the on-chip memory interface
// assumes nothing of its surroundings

package tcm_pkg;

    // ==========================================================
    // control register bus
    localparam int CBUS_AW = 10;
    localparam int CBUS_DW = 32;

    // register offsets from each side's base address
    localparam logic [9:0] DS_CTRL_OFS = 10'h0;
    localparam logic [9:0] DS_RANGE_OFS = 10'h1;
    localparam logic [9:0] IS_CTRL_OFS = 10'h0;
    localparam logic [9:0] IS_RANGE_OFS = 10'h1;
    localparam logic [9:0] IS_INIT_OFS = 10'h2;
    localparam logic [9:0] IS_FILL_OFS = 10'h3;
    localparam int DS_REG_COUNT = 2;
    localparam int IS_REG_COUNT = 4;

    // ==========================================================
    // control register fields (8 bits)
    localparam int CTL_W = 8;
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_MULTI_BIT = 6;
    localparam int CTL_CNT_LSB = 0;
    localparam int CTL_CNT_W = 3;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] RANGE_RST = 8'h00;
    localparam logic [31:0] INIT_RST = 32'h0;
    localparam logic [31:0] FILL_RST = 32'h0;

    // ==========================================================
    // access timing, in processor clock cycles
    localparam int CYC_W = 4;
    localparam logic [3:0] SINGLE_CYCLES = 4'h1;
    localparam logic [3:0] MULTI_MIN_CYCLES = 4'h2;
    localparam logic [3:0] MULTI_MAX_CYCLES = 4'h8;

    // ==========================================================
    // address layout
    localparam int CPU_AW = 32;
    localparam int REGION_LSB = 24;
    localparam int DS_RAM_AW = 22;
    localparam int IS_RAM_AW = 21;
    localparam logic [31:0] FILL_STEP = 32'h4;

    // ==========================================================
    // sequencer states
    typedef enum logic [0:0] {
        TCM_DS_IDLE = 1'b0,
        TCM_DS_BUSY = 1'b1
    } tcm_ds_state_t;

    typedef enum logic [1:0] {
        TCM_IS_IDLE = 2'b00,
        TCM_IS_FETCH = 2'b01,
        TCM_IS_WRITE = 2'b10
    } tcm_is_state_t;

endpackage

/* verif/cpu_on_chip_memory_if_tb_top.sv */
// self-checking testbench of the on-chip memory interface
// assumes the ram model and the bound port checker
`timescale 1ns/10ps

// ==========
// testbench
module cpu_on_chip_memory_if_tb_top;
    localparam logic [9:0] DSB = 10'h010;
    localparam logic [9:0] ISB = 10'h018;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] c_addr = 10'h0;
    logic c_rd = 1'b0;
    logic c_wr = 1'b0;
    logic [31:0] c_wdata = 32'h0;
    logic ds_req = 1'b0;
    logic ds_we = 1'b0;
    logic [3:0] ds_be = 4'h0;
    logic [31:0] ds_addr = 32'h0;
    logic [31:0] ds_wdata = 32'h0;
    logic is_req = 1'b0;
    logic [31:0] is_addr = 32'h0;
    logic f_we = 1'b0;
    logic [7:0] f_addr = 8'h0;
    logic [31:0] f_wdata = 32'h0;
    wire logic [31:0] c_rdata, ds_rdata, dm_wdata, dm_rdata, im_wdata, f_rdata;
    wire logic c_ack, ds_done, dm_en, is_done, im_en;
    wire logic [3:0] dm_we;
    wire logic [21:0] dm_addr;
    wire logic [1:0] im_we;
    wire logic [20:0] im_addr;
    wire logic [63:0] is_rdata, im_rdata;
    int errors = 0;
    int checks_done = 0;
    int cyc;
    logic [63:0] q;

    always #2.5 mclk = ~mclk;

    tcm_mem_if dut_u (
        .MCLK_I(mclk), .RST_N_I(rst_n), .CBUS_ADDR_I(c_addr),
        .CBUS_RD_I(c_rd), .CBUS_WR_I(c_wr), .CBUS_WDATA_I(c_wdata),
        .CBUS_RDATA_O(c_rdata), .CBUS_ACK_O(c_ack), .DS_REQ_I(ds_req),
        .DS_WE_I(ds_we), .DS_BE_I(ds_be), .DS_ADDR_I(ds_addr),
        .DS_WDATA_I(ds_wdata), .DS_RDATA_O(ds_rdata), .DS_DONE_O(ds_done),
        .DMEM_EN_O(dm_en), .DMEM_WE_O(dm_we), .DMEM_ADDR_O(dm_addr),
        .DMEM_WDATA_O(dm_wdata), .DMEM_RDATA_I(dm_rdata),
        .IS_REQ_I(is_req), .IS_ADDR_I(is_addr), .IS_RDATA_O(is_rdata),
        .IS_DONE_O(is_done), .IMEM_EN_O(im_en), .IMEM_WE_O(im_we),
        .IMEM_ADDR_O(im_addr), .IMEM_WDATA_O(im_wdata),
        .IMEM_RDATA_I(im_rdata)
    );
    tcm_ram_model model_u (
        .clk_i(mclk), .den_i(dm_en), .dwe_i(dm_we), .daddr_i(dm_addr),
        .dwdata_i(dm_wdata), .drdata_o(dm_rdata), .fwe_i(f_we),
        .faddr_i(f_addr), .fwdata_i(f_wdata), .frdata_o(f_rdata),
        .ien_i(im_en), .iwe_i(im_we), .iaddr_i(im_addr),
        .iwdata_i(im_wdata), .irdata_o(im_rdata)
    );

    // ==========
    // shared tasks
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cbus(input logic rd, input logic [9:0] a,
                        input logic [31:0] d);
        @(posedge mclk);
        c_rd <= rd;
        c_wr <= !rd;
        c_addr <= a;
        c_wdata <= d;
        @(posedge mclk);
        c_rd <= 1'b0;
        c_wr <= 1'b0;
        #1;
        q = {31'h0, c_ack, c_rdata};
    endtask
    task automatic wait_done(input logic is_side, input logic may_miss);
        #1;
        cyc = 0;
        while ((is_side ? is_done : ds_done) !== 1'b1 && cyc < 12) begin
            @(posedge mclk);
            #1;
            cyc++;
        end
        if (cyc == 12 && !may_miss) begin
            errors++;
            $display("FAIL %0t done timeout", $time);
            give_verdict();
        end
    endtask
    task automatic ds_acc(input logic we, input logic [3:0] be,
                          input logic [31:0] a, input logic [31:0] d,
                          input logic may_miss);
        @(posedge mclk);
        ds_req <= 1'b1;
        ds_we <= we;
        ds_be <= be;
        ds_addr <= a;
        ds_wdata <= d;
        @(posedge mclk);
        ds_req <= 1'b0;
        wait_done(1'b0, may_miss);
        q = {32'h0, ds_rdata};
    endtask
    task automatic is_fetch(input logic [31:0] a);
        @(posedge mclk);
        is_req <= 1'b1;
        is_addr <= a;
        @(posedge mclk);
        is_req <= 1'b0;
        wait_done(1'b1, 1'b0);
        q = is_rdata;
    endtask

    // ==========
    // scenarios
    task automatic t_regs;
        for (int k = 0; k < 6; k++) begin
            cbus(1'b1, (k < 2) ? DSB + k[9:0] : ISB + k[9:0] - 10'h2, 32'h0);
            chk(q, 64'h1_0000_0000);
        end
        cbus(1'b1, 10'h3ff, 32'h0);
        chk(q, 64'h0);
        cbus(1'b1, ISB + 10'h4, 32'h0);
        chk(q, 64'h0);
        cbus(1'b0, DSB + 10'h1, 32'hffff_ff40);
        cbus(1'b1, DSB + 10'h1, 32'h0);
        chk(q, 64'h1_0000_0040);
        cbus(1'b0, ISB + 10'h3, 32'h0000_0100);
        cbus(1'b1, ISB + 10'h3, 32'h0);
        chk(q, 64'h1_0000_0100);
        $display("test regs done");
    endtask
    task automatic t_ds_bytes;
        cbus(1'b0, DSB, 32'h80);
        @(posedge mclk);
        f_we <= 1'b1;
        f_addr <= 8'h04;
        f_wdata <= 32'h8877_6655;
        @(posedge mclk);
        f_we <= 1'b0;
        ds_acc(1'b1, 4'h5, 32'h4000_0010, 32'haabb_ccdd, 1'b0);
        chk(64'(cyc), 64'h1);
        ds_acc(1'b0, 4'h0, 32'h4000_0010, 32'h0, 1'b0);
        chk(q, 64'h88bb_66dd);
        chk({32'h0, f_rdata}, 64'h88bb_66dd);
        ds_acc(1'b1, 4'hf, 32'h4000_fffc, 32'h1234_5678, 1'b0);
        ds_acc(1'b0, 4'h0, 32'h4000_fffc, 32'h0, 1'b0);
        chk(q, 64'h1234_5678);
        $display("test data bytes done");
    endtask
    task automatic t_ds_multi;
        for (int n = 0; n < 8; n++) begin
            cbus(1'b0, DSB, 32'hc0 | n);
            ds_acc(1'b0, 4'h0, 32'h4000_0010, 32'h0, 1'b0);
            chk(64'(cyc), (n == 0) ? 64'h2 : 64'(n + 1));
            chk(q, 64'h88bb_66dd);
        end
        cbus(1'b0, DSB, 32'h80);
        ds_acc(1'b0, 4'h0, 32'h4100_0010, 32'h0, 1'b1);
        chk(64'(cyc), 64'hc);
        $display("test data multi done");
    endtask
    task automatic t_is;
        cbus(1'b0, ISB + 10'h1, 32'h20);
        cbus(1'b0, ISB, 32'h80);
        is_fetch(32'h2000_0018);
        chk(q, 64'hc0de_0003_5a5a_0003);
        chk(64'(cyc), 64'h1);
        cbus(1'b0, ISB + 10'h2, 32'h1111_aaaa);
        cbus(1'b0, ISB + 10'h2, 32'h2222_bbbb);
        repeat (2) @(posedge mclk);
        cbus(1'b1, ISB + 10'h3, 32'h0);
        chk(q, 64'h1_0000_0108);
        cbus(1'b0, ISB, 32'hc3);
        is_fetch(32'h2000_0100);
        chk(q, 64'h2222_bbbb_1111_aaaa);
        chk(64'(cyc), 64'h4);
        $display("test instruction side done");
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_ds_bytes();
        t_ds_multi();
        t_is();
        give_verdict();
    end
endmodule // cpu_on_chip_memory_if_tb_top

/* verif/tcm_mem_if_monitor.sv */
// checker on the ports of the on-chip memory interface top
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/10ps

// ==========
// port checker
module tcm_mem_if_monitor (
    // clock and reset
    input logic MCLK_I,
    input logic RST_N_I,
    // control bus
    input logic CBUS_RD_I,
    input logic CBUS_WR_I,
    input logic [31:0] CBUS_RDATA_O,
    input logic CBUS_ACK_O,
    // data side
    input logic [31:0] DS_ADDR_I,
    input logic [31:0] DS_RDATA_O,
    input logic DS_DONE_O,
    input logic DMEM_EN_O,
    input logic [3:0] DMEM_WE_O,
    input logic [21:0] DMEM_ADDR_O,
    input logic [31:0] DMEM_RDATA_I,
    // instruction side
    input logic [31:0] IS_ADDR_I,
    input logic [63:0] IS_RDATA_O,
    input logic IS_DONE_O,
    input logic IMEM_EN_O,
    input logic [1:0] IMEM_WE_O,
    input logic [20:0] IMEM_ADDR_O,
    input logic [63:0] IMEM_RDATA_I
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [3:0] en_cnt_r;
    // data ram enable run length
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I)
            en_cnt_r <= 4'h0;
        else
            en_cnt_r <= DMEM_EN_O ? en_cnt_r + 4'h1 : 4'h0;
    end
    sequence s_ds_start;
        $rose(DMEM_EN_O);
    endsequence
    sequence s_fetch_start;
        $rose(IMEM_EN_O) && IMEM_WE_O == 2'h0;
    endsequence
    property p_ds_len;
        en_cnt_r <= 4'h8;
    endproperty
    property p_ds_done;
        DS_DONE_O |-> !DMEM_EN_O && $past(DMEM_EN_O);
    endproperty
    property p_ds_addr;
        s_ds_start |-> DMEM_ADDR_O == $past(DS_ADDR_I[23:2]);
    endproperty
    property p_ds_rd;
        DS_DONE_O && $past(DMEM_WE_O) == 4'h0 |->
            DS_RDATA_O == $past(DMEM_RDATA_I);
    endproperty
    property p_ds_keep;
        !DS_DONE_O |-> $stable(DS_RDATA_O);
    endproperty
    property p_we_en;
        DMEM_WE_O != 4'h0 |-> DMEM_EN_O;
    endproperty
    property p_is_done;
        IS_DONE_O |-> $past(IMEM_EN_O) && $past(IMEM_WE_O) == 2'h0 &&
            IS_RDATA_O == $past(IMEM_RDATA_I);
    endproperty
    property p_is_addr;
        s_fetch_start |-> IMEM_ADDR_O == $past(IS_ADDR_I[23:3]);
    endproperty
    property p_is_we;
        IMEM_WE_O != 2'h0 |-> $onehot(IMEM_WE_O) && IMEM_EN_O;
    endproperty
    property p_ack;
        CBUS_ACK_O |-> $past(CBUS_RD_I) || $past(CBUS_WR_I);
    endproperty
    property p_rdz;
        !CBUS_ACK_O |-> CBUS_RDATA_O == 32'h0;
    endproperty
    a_ds_len: assert property (p_ds_len)
        else $error("data access over eight cycles");
    a_ds_done: assert property (p_ds_done)
        else $error("done not at end of access");
    a_ds_addr: assert property (p_ds_addr)
        else $error("data ram address wrong");
    a_ds_rd: assert property (p_ds_rd)
        else $error("data read not from last cycle");
    a_ds_keep: assert property (p_ds_keep)
        else $error("read data changed without done");
    a_we_en: assert property (p_we_en)
        else $error("byte write outside access");
    a_is_done: assert property (p_is_done)
        else $error("fetch data wrong");
    a_is_addr: assert property (p_is_addr)
        else $error("fetch address wrong");
    a_is_we: assert property (p_is_we)
        else $error("write half select wrong");
    a_ack: assert property (p_ack)
        else $error("ack without strobe");
    a_rdz: assert property (p_rdz)
        else $error("read data outside ack");
endmodule // tcm_mem_if_monitor

bind tcm_mem_if tcm_mem_if_monitor mon_u (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CBUS_RD_I(CBUS_RD_I),
    .CBUS_WR_I(CBUS_WR_I), .CBUS_RDATA_O(CBUS_RDATA_O),
    .CBUS_ACK_O(CBUS_ACK_O), .DS_ADDR_I(DS_ADDR_I),
    .DS_RDATA_O(DS_RDATA_O), .DS_DONE_O(DS_DONE_O),
    .DMEM_EN_O(DMEM_EN_O), .DMEM_WE_O(DMEM_WE_O),
    .DMEM_ADDR_O(DMEM_ADDR_O), .DMEM_RDATA_I(DMEM_RDATA_I),
    .IS_ADDR_I(IS_ADDR_I), .IS_RDATA_O(IS_RDATA_O),
    .IS_DONE_O(IS_DONE_O), .IMEM_EN_O(IMEM_EN_O),
    .IMEM_WE_O(IMEM_WE_O), .IMEM_ADDR_O(IMEM_ADDR_O),
    .IMEM_RDATA_I(IMEM_RDATA_I)
);

/* verif/tcm_ram_model.sv */
// behavioural dual-port block ram pair seen by the memory interface
// assumes small arrays indexed by the low address bits
`timescale 1ns/10ps

// ==========
// ram model
module tcm_ram_model (
    // clock
    input logic clk_i,
    // data ram first port
    input logic den_i,
    input logic [3:0] dwe_i,
    input logic [21:0] daddr_i,
    input logic [31:0] dwdata_i,
    output logic [31:0] drdata_o,
    // data ram second port for fabric logic
    input logic fwe_i,
    input logic [7:0] faddr_i,
    input logic [31:0] fwdata_i,
    output logic [31:0] frdata_o,
    // instruction ram port
    input logic ien_i,
    input logic [1:0] iwe_i,
    input logic [20:0] iaddr_i,
    input logic [31:0] iwdata_i,
    output logic [63:0] irdata_o
);
    logic [31:0] dmem [256];
    logic [63:0] imem [256];
    // preloaded contents, as from the bitstream
    initial begin
        for (int k = 0; k < 256; k++) begin
            imem[k] = {24'hc0de00, k[7:0], 24'h5a5a00, k[7:0]};
            dmem[k] = 32'h0;
        end
    end
    // data and instruction read views valid while enabled, inverted otherwise; fabric read view always valid
    assign drdata_o = den_i ? dmem[daddr_i[7:0]] : ~dmem[daddr_i[7:0]];
    assign irdata_o = ien_i ? imem[iaddr_i[7:0]] : ~imem[iaddr_i[7:0]];
    assign frdata_o = dmem[faddr_i];
    // instruction ram has no fabric write port, held idle
    always @(posedge clk_i) begin
        for (int b = 0; b < 4; b++) begin
            if (den_i && dwe_i[b])
                dmem[daddr_i[7:0]][8*b +: 8] <= dwdata_i[8*b +: 8];
        end
        if (fwe_i)
            dmem[faddr_i] <= fwdata_i;
        if (ien_i && iwe_i[0])
            imem[iaddr_i[7:0]][31:0] <= iwdata_i;
        if (ien_i && iwe_i[1])
            imem[iaddr_i[7:0]][63:32] <= iwdata_i;
    end
endmodule // tcm_ram_model
